// ---- power_reset_clock_control.sv ----
/*
 * power, reset and clock supervision: regulator on/off, reset combining,
 * regulator voltage settings, pll multiplier selection and analog driver enable.
 * assumes pin levels are asynchronous and software controls are on i_sys_clk.
 */
//
// Behaviour
// - regulators stay on after key released
// - key level readable as status
// - core monitor low forces internal reset
// - key held over 5.6 s resets
// - watchdog expiry and external pin reset
// - resets keep regulators on, restore voltages
// - software may reprogram voltages after boot
// - only shutdown write or enabled 2 s key hold turns regulators off
// - key held 2 s powers down
// - io 1.8 V, strap selects 3.3 V
// - multiplier 1.0 to 4.0, half steps
// - usb connected runs at 4x
// - player mode follows song, max 3.5x
// - external reset stops clock, powers down digital
// - analog 3.6 V with usb, mode settings
// - analog supply low readable
// - analog drivers enabled at decode start
`timescale 1ns/1ps
module power_reset_clock_control #(
   parameter int unsigned START_CYC = prcc_pkg::START_CYC,
   parameter int unsigned LONG_RESET_CYC = prcc_pkg::LONG_RESET_CYC,
   parameter int unsigned AUTO_OFF_CYC = prcc_pkg::AUTO_OFF_CYC,
   parameter int unsigned WDOG_CYC = prcc_pkg::WDOG_CYC
) (
   // clock and main supply reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // pins and analog monitors
   input wire logic i_power_key_input,
   input wire logic i_ext_reset_n,
   input wire logic i_core_monitor_low,
   input wire logic i_analog_supply_low,
   input wire logic i_io_level_strap,
   // software control
   input wire logic i_reg_shutdown,
   input wire logic i_volt_wr,
   input wire prcc_pkg::volt_cfg_t i_volt_cfg,
   input wire logic i_auto_off_en,
   input wire logic i_mult_wr,
   input wire logic [2:0] i_mult,
   input wire logic i_usb_connected,
   input wire logic i_player_mode,
   input wire logic [2:0] i_song_mult,
   input wire logic i_wdog_en,
   input wire logic i_wdog_kick,
   input wire logic i_decode_start,
   input wire logic i_decode_stop,
   input wire logic i_cause_clr,
   // outputs
   output logic o_reg_enable,
   output prcc_pkg::volt_cfg_t o_volt,
   output logic [2:0] o_pll_mult,
   output logic o_sys_reset_n,
   output logic o_clk_buf_en,
   output logic o_digital_pd,
   output prcc_pkg::status_t o_status,
   output logic o_analog_drv_en
);

   // limit a multiplier code to a ceiling
   function automatic logic [2:0] clamp_mult(input logic [2:0] code, input logic [2:0] lim);
      clamp_mult = (code > lim) ? lim : code;
   endfunction

   // synchronised pin levels
   logic [4:0] pins_s;
   logic key_s;
   logic ext_n_s;
   logic core_low_s;
   logic an_low_s;
   logic strap_s;

   prcc_sync #(
      .WIDTH(5),
      .RST_VAL(5'h08) // reset pin idles high, no false cause after reset
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .i_async({i_power_key_input, i_ext_reset_n, i_core_monitor_low, i_analog_supply_low, i_io_level_strap}),
      .o_sync(pins_s)
   );

   // unpack synchronised levels
   assign key_s = pins_s[4];
   assign ext_n_s = pins_s[3];
   assign core_low_s = pins_s[2];
   assign an_low_s = pins_s[1];
   assign strap_s = pins_s[0];

   prcc_pkg::reg_state_t state_r;
   logic [31:0] key_cnt_r;
   logic key_armed_r;
   logic start_p;
   logic long_rst_p;
   logic auto_off_p;
   logic [31:0] wd_cnt_r;
   logic wd_exp_p;
   logic [3:0] src;
   logic src_any;
   logic [2:0] rst_cnt_r;
   logic strap_done_r;
   prcc_pkg::volt_cfg_t volt_r;
   logic [2:0] mult_sw_r;
   logic [2:0] mult_nxt;

   // consecutive key-held counter, saturating
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         key_cnt_r <= 32'h0;
      else if (!key_s)
         key_cnt_r <= 32'h0;
      else if (key_cnt_r != 32'hFFFFFFFF)
         key_cnt_r <= key_cnt_r + 32'h1;
   end

   // key press events
   assign start_p = key_s && (key_cnt_r == 32'(START_CYC - 1));
   assign long_rst_p = key_s && (key_cnt_r == 32'(LONG_RESET_CYC));
   assign auto_off_p = key_s && key_armed_r && i_auto_off_en
                       && (key_cnt_r == 32'(AUTO_OFF_CYC - 1));

   // the starting press must be released before a hold can power down
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         key_armed_r <= 1'b0;
      else if (state_r == prcc_pkg::REG_OFF)
         key_armed_r <= 1'b0;
      else if (!key_s)
         key_armed_r <= 1'b1;
   end

   // regulator state: reset sources never turn it off
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         state_r <= prcc_pkg::REG_OFF;
      else
      begin
         case (state_r)
            prcc_pkg::REG_OFF:
            begin
               if (start_p)
                  state_r <= prcc_pkg::REG_ON;
            end
            prcc_pkg::REG_ON:
            begin
               if (i_reg_shutdown || auto_off_p)
                  state_r <= prcc_pkg::REG_OFF;
            end
            default:
               state_r <= prcc_pkg::REG_OFF;
         endcase
      end
   end

   // regulator enable follows state
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         o_reg_enable <= 1'b0;
      else
         o_reg_enable <= (state_r == prcc_pkg::REG_ON);
   end

   // watchdog counter
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         wd_cnt_r <= 32'h0;
      else if (!i_wdog_en || i_wdog_kick || !o_sys_reset_n || wd_exp_p)
         wd_cnt_r <= 32'h0;
      else
         wd_cnt_r <= wd_cnt_r + 32'h1;
   end

   assign wd_exp_p = i_wdog_en && !i_wdog_kick && (wd_cnt_r == 32'(WDOG_CYC - 1));

   // reset sources
   assign src[prcc_pkg::CAUSE_CORE] = core_low_s;
   assign src[prcc_pkg::CAUSE_LONG] = long_rst_p;
   assign src[prcc_pkg::CAUSE_WDOG] = wd_exp_p;
   assign src[prcc_pkg::CAUSE_EXT] = !ext_n_s;
   assign src_any = (|src) || (state_r == prcc_pkg::REG_OFF);

   // combined reset, stretched and released on the clock
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         rst_cnt_r <= prcc_pkg::RST_STRETCH;
         o_sys_reset_n <= 1'b0;
      end
      else if (src_any)
      begin
         rst_cnt_r <= prcc_pkg::RST_STRETCH;
         o_sys_reset_n <= 1'b0;
      end
      else if (rst_cnt_r != 3'h0)
      begin
         rst_cnt_r <= rst_cnt_r - 3'h1;
         o_sys_reset_n <= 1'b0;
      end
      else
         o_sys_reset_n <= 1'b1;
   end

   // clock buffer and digital powerdown from the external pin
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         o_clk_buf_en <= 1'b0;
         o_digital_pd <= 1'b1;
      end
      else
      begin
         o_clk_buf_en <= ext_n_s && (state_r == prcc_pkg::REG_ON);
         o_digital_pd <= !ext_n_s || (state_r == prcc_pkg::REG_OFF);
      end
   end

   // strap is caught once after each reset release
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn || !o_sys_reset_n)
         strap_done_r <= 1'b0;
      else
         strap_done_r <= 1'b1;
   end

   // voltage settings: defaults on any reset, then strap and software
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn || !o_sys_reset_n)
         volt_r <= prcc_pkg::VOLT_DEF;
      else if (i_volt_wr)
         volt_r <= i_volt_cfg;
      else if (!strap_done_r)
         volt_r.io <= strap_s ? prcc_pkg::IO_3V3 : prcc_pkg::IO_1V8;
   end

   // usb forces the analog supply up
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         o_volt <= prcc_pkg::VOLT_DEF;
      else
      begin
         o_volt <= volt_r;
         if (i_usb_connected && o_sys_reset_n)
            o_volt.analog <= prcc_pkg::AN_3V6;
      end
   end

   // software multiplier setting
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn || !o_sys_reset_n)
         mult_sw_r <= prcc_pkg::MULT_X1;
      else if (i_mult_wr)
         mult_sw_r <= clamp_mult(i_mult, prcc_pkg::MULT_X4);
   end

   // multiplier selection by mode
   always_comb
   begin
      if (!o_sys_reset_n)
         mult_nxt = prcc_pkg::MULT_X1;
      else if (i_usb_connected)
         mult_nxt = prcc_pkg::MULT_X4;
      else if (i_player_mode)
         mult_nxt = clamp_mult(i_song_mult, prcc_pkg::MULT_X3_5);
      else
         mult_nxt = mult_sw_r;
   end

   // pll multiplier output
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         o_pll_mult <= prcc_pkg::MULT_X1;
      else
         o_pll_mult <= mult_nxt;
   end

   // analog drivers: on at decode start, start wins over stop
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn || !o_sys_reset_n)
         o_analog_drv_en <= 1'b0;
      else if (i_decode_start)
         o_analog_drv_en <= 1'b1;
      else if (i_decode_stop)
         o_analog_drv_en <= 1'b0;
   end

   // status levels and sticky reset causes, set wins over clear
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
         o_status <= '0;
      else
      begin
         o_status.key <= key_s;
         o_status.analog_low <= an_low_s;
         o_status.reg_on <= (state_r == prcc_pkg::REG_ON);
         o_status.cause <= (i_cause_clr ? 4'h0 : o_status.cause) | src;
      end
   end

   // checks on the logic above
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);

   sequence src_seen;
      src_any;
   endsequence

   sequence quiet_five;
      (!src_any) [*5];
   endsequence

   key_status_a: assert property (##3 (o_status.key == $past(i_power_key_input, 3)))
      else $error("key status does not follow the power key pin");

   core_mon_a: assert property (core_low_s |=> !o_sys_reset_n)
      else $error("core monitor low did not reset");

   ext_pin_a: assert property (!ext_n_s |=> !o_sys_reset_n && !o_clk_buf_en && o_digital_pd)
      else $error("external reset did not stop clock and digital");

   only_sw_off_a: assert property ((state_r == prcc_pkg::REG_ON) && !i_reg_shutdown && !auto_off_p
                                   |=> state_r == prcc_pkg::REG_ON)
      else $error("regulators turned off without shutdown");

   reset_default_a: assert property (!o_sys_reset_n |=> volt_r == prcc_pkg::VOLT_DEF)
      else $error("reset did not restore default voltages");

   release_sync_a: assert property (src_seen ##1 quiet_five |=> o_sys_reset_n)
      else $error("reset not released after stretch");

   hold_reset_a: assert property (src_seen |-> ##1 (!o_sys_reset_n) [*5])
      else $error("reset released too early");

   usb_mult_a: assert property (i_usb_connected && o_sys_reset_n |=> o_pll_mult == prcc_pkg::MULT_X4)
      else $error("usb clock is not four times input");

   player_cap_a: assert property (!i_usb_connected && i_player_mode |=> o_pll_mult <= prcc_pkg::MULT_X3_5)
      else $error("player clock above 3.5 times");

   strap_io_a: assert property ($rose(o_sys_reset_n) && !i_volt_wr && !src_any
                                |=> volt_r.io == ($past(strap_s) ? prcc_pkg::IO_3V3 : prcc_pkg::IO_1V8))
      else $error("io voltage does not follow strap");

   volt_write_a: assert property (o_sys_reset_n && i_volt_wr && !src_any |=> volt_r == $past(i_volt_cfg))
      else $error("voltage write not taken");

   analog_on_a: assert property ($rose(o_analog_drv_en) |-> $past(i_decode_start))
      else $error("analog drivers enabled without decode start");

   long_press_a: assert property (long_rst_p && state_r == prcc_pkg::REG_ON
                                  |=> !o_sys_reset_n && o_status.cause[prcc_pkg::CAUSE_LONG])
      else $error("long press did not reset");

   auto_off_a: assert property (auto_off_p |=> state_r == prcc_pkg::REG_OFF ##1 !o_reg_enable)
      else $error("two second hold did not power down");

   start_on_a: assert property (start_p && state_r == prcc_pkg::REG_OFF |=> ##1 o_reg_enable)
      else $error("start press did not enable regulators");

endmodule // power_reset_clock_control

// ---- prcc_partner.sv ----
/*
 * power key, rail monitors, reset pin and strap that surround the block.
 * assumes the bench calls its tasks just after a rising edge of i_sys_clk.
 */
`timescale 1ns/1ps
module prcc_partner (
   // clock
   input wire logic i_sys_clk,
   // pins towards the block
   output logic o_key,
   output logic o_ext_reset_n,
   output logic o_core_low,
   output logic o_analog_low,
   output logic o_strap
);
   // idle levels: key pulled down, strap pulled up
   initial
   begin
      o_key = 1'b0;
      o_ext_reset_n = 1'b1;
      o_core_low = 1'b0;
      o_analog_low = 1'b0;
      o_strap = 1'b1;
   end

   // 0 core low, 1 reset pin, 2 analog low, 3 key, 4 strap pulled down
   task automatic set_pin(input int which, input logic v);
      case (which)
         0: o_core_low <= v;
         1: o_ext_reset_n <= !v;
         2: o_analog_low <= v;
         3: o_key <= v;
         4: o_strap <= !v;
         default: ;
      endcase
   endtask

   // start press, long enough to start yet far below the upper limit
   task automatic press(input int n);
      @(posedge i_sys_clk);
      o_key <= 1'b1;
      repeat (n) @(posedge i_sys_clk);
      o_key <= 1'b0;
   endtask
endmodule // prcc_partner

// ---- prcc_pkg.sv ----
/*
 * shared constants and types for the power, reset and clock control block.
 * assumes a 250 MHz system clock; all times are turned into cycle counts here.
 */
package prcc_pkg;

   // clock rate and times in their own units
   localparam int unsigned CLK_KHZ = 250000;
   localparam int unsigned START_MIN_MS = 1;
   localparam int unsigned LONG_RESET_MS = 5600;
   localparam int unsigned AUTO_OFF_MS = 2000;
   localparam int unsigned WDOG_MS = 1000;

   // derived cycle counts
   localparam int unsigned START_CYC = START_MIN_MS * CLK_KHZ;
   localparam int unsigned LONG_RESET_CYC = LONG_RESET_MS * CLK_KHZ;
   localparam int unsigned AUTO_OFF_CYC = AUTO_OFF_MS * CLK_KHZ;
   localparam int unsigned WDOG_CYC = WDOG_MS * CLK_KHZ;
   localparam logic [2:0] RST_STRETCH = 3'h4;

   // multiplier codes: factor = (code + 2) / 2
   localparam logic [2:0] MULT_X1 = 3'h0;
   localparam logic [2:0] MULT_X3_5 = 3'h5;
   localparam logic [2:0] MULT_X4 = 3'h6;

   // regulator voltage codes
   localparam logic [3:0] CORE_DEF = 4'h8;
   localparam logic [3:0] IO_1V8 = 4'h0;
   localparam logic [3:0] IO_3V3 = 4'h1;
   localparam logic [3:0] AN_DEF = 4'h6;
   localparam logic [3:0] AN_3V6 = 4'hF;

   // reset cause bit positions
   localparam int CAUSE_CORE = 0;
   localparam int CAUSE_LONG = 1;
   localparam int CAUSE_WDOG = 2;
   localparam int CAUSE_EXT = 3;

   typedef struct packed {
      logic [3:0] core;
      logic [3:0] io;
      logic [3:0] analog;
   } volt_cfg_t;

   localparam volt_cfg_t VOLT_DEF = '{core: CORE_DEF, io: IO_1V8, analog: AN_DEF};

   typedef struct packed {
      logic key;
      logic analog_low;
      logic reg_on;
      logic [3:0] cause;
   } status_t;

   typedef enum logic [0:0] {
      REG_OFF = 1'b0,
      REG_ON = 1'b1
   } reg_state_t;

endpackage

// ---- prcc_sync.sv ----
/*
 * two flip-flop synchroniser for a group of pin levels.
 * assumes each bit is a slow level; no bus coherency between bits.
 */
`timescale 1ns/1ps
module prcc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // levels
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_r;

   // first stage feeds only the second stage; both stages reset to RST_VAL
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_rstn)
      begin
         meta_r <= RST_VAL;
         o_sync <= RST_VAL;
      end
      else
      begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule // prcc_sync

// ---- testbench.sv ----
/*
 * self-checking bench for power_reset_clock_control with short counts.
 * assumes the partner model drives the pins and the bench the software side.
 */
`timescale 1ns/1ps
module testbench;
   localparam int START = 4;
   localparam int LONGC = 40;
   localparam int AUTO = 20;
   localparam int WDOG = 30;
   logic i_sys_clk, i_rstn, key, ext_n, core_low, an_low, strap;
   logic i_reg_shutdown, i_volt_wr, i_auto_off_en, i_mult_wr, i_usb_connected, i_player_mode;
   logic i_wdog_en, i_wdog_kick, i_decode_start, i_decode_stop, i_cause_clr;
   logic [2:0] i_mult, i_song_mult;
   prcc_pkg::volt_cfg_t i_volt_cfg, o_volt;
   prcc_pkg::status_t o_status;
   logic o_reg_enable, o_sys_reset_n, o_clk_buf_en, o_digital_pd, o_analog_drv_en;
   logic [2:0] o_pll_mult;
   int err_total, checks;

   // clock, steady reference for the usb modes
   always #2 i_sys_clk = ~i_sys_clk;

   prcc_partner i_prcc_partner (.i_sys_clk(i_sys_clk), .o_key(key), .o_ext_reset_n(ext_n),
      .o_core_low(core_low), .o_analog_low(an_low), .o_strap(strap));

   power_reset_clock_control #(.START_CYC(START), .LONG_RESET_CYC(LONGC), .AUTO_OFF_CYC(AUTO),
      .WDOG_CYC(WDOG)) i_power_reset_clock_control (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
      .i_power_key_input(key), .i_ext_reset_n(ext_n), .i_core_monitor_low(core_low),
      .i_analog_supply_low(an_low), .i_io_level_strap(strap), .i_reg_shutdown(i_reg_shutdown),
      .i_volt_wr(i_volt_wr), .i_volt_cfg(i_volt_cfg), .i_auto_off_en(i_auto_off_en),
      .i_mult_wr(i_mult_wr), .i_mult(i_mult), .i_usb_connected(i_usb_connected),
      .i_player_mode(i_player_mode), .i_song_mult(i_song_mult), .i_wdog_en(i_wdog_en),
      .i_wdog_kick(i_wdog_kick), .i_decode_start(i_decode_start), .i_decode_stop(i_decode_stop),
      .i_cause_clr(i_cause_clr), .o_reg_enable(o_reg_enable), .o_volt(o_volt),
      .o_pll_mult(o_pll_mult), .o_sys_reset_n(o_sys_reset_n), .o_clk_buf_en(o_clk_buf_en),
      .o_digital_pd(o_digital_pd), .o_status(o_status), .o_analog_drv_en(o_analog_drv_en));

   // verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // compare seen against expected
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   // 0 regulators, otherwise internal reset
   function automatic logic pick(input int sel);
      pick = (sel == 0) ? o_reg_enable : o_sys_reset_n;
   endfunction

   // bounded wait for a level, sampled after the edge has settled
   task automatic wait_until(input int sel, input logic val, input int bound);
      int n;
      n = 0;
      #1;
      while (pick(sel) !== val)
      begin
         if (n == bound)
         begin
            err_total++;
            $display("mismatch at %0t: wait ran out", $time);
            tally_and_finish();
         end
         else
         begin
            @(posedge i_sys_clk);
            #1;
            n++;
         end
      end
   endtask

   // one-cycle control pulse
   task automatic pulse(input int which);
      @(posedge i_sys_clk);
      case (which)
         0: i_volt_wr <= 1'b1;
         1: i_mult_wr <= 1'b1;
         2: i_cause_clr <= 1'b1;
         3: i_decode_start <= 1'b1;
         4: i_decode_stop <= 1'b1;
         5: i_wdog_kick <= 1'b1;
         6: i_reg_shutdown <= 1'b1;
         default: ;
      endcase
      @(posedge i_sys_clk);
      {i_volt_wr, i_mult_wr, i_cause_clr, i_decode_start, i_decode_stop, i_wdog_kick, i_reg_shutdown} <= '0;
      @(posedge i_sys_clk);
      #1;
   endtask

   // start press, regulators up, reset released, strap captured
   task automatic t_power_up();
      @(posedge i_sys_clk);
      #1;
      check(o_reg_enable, 1'b0);
      check(o_sys_reset_n, 1'b0);
      i_prcc_partner.press(START + 4);
      wait_until(0, 1'b1, 40);
      wait_until(1, 1'b1, 40);
      repeat (4) @(posedge i_sys_clk);
      #1;
      check(o_reg_enable, 1'b1);
      check(o_status.reg_on, 1'b1);
      check(o_volt.io, prcc_pkg::IO_3V3);
   endtask

   // key level reaches status through the synchroniser
   task automatic t_key_status();
      @(posedge i_sys_clk);
      i_prcc_partner.set_pin(3, 1'b1);
      repeat (2) @(posedge i_sys_clk);
      #1;
      check(o_status.key, 1'b0);
      @(posedge i_sys_clk);
      #1;
      check(o_status.key, 1'b1);
      i_prcc_partner.set_pin(3, 1'b0);
   endtask

   // voltages, multiplier modes and analog side
   task automatic t_settings();
      i_volt_cfg <= '{core: 4'h3, io: 4'h1, analog: 4'h9};
      pulse(0);
      check(o_volt, 12'h319);
      for (int c = 0; c < 8; c++)
      begin
         i_mult <= 3'(c);
         pulse(1);
         check(o_pll_mult, (c > 6) ? 12'h6 : 12'(c));
      end
      i_player_mode <= 1'b1;
      i_song_mult <= 3'h7;
      pulse(7);
      check(o_pll_mult, prcc_pkg::MULT_X3_5);
      i_usb_connected <= 1'b1;
      pulse(7);
      check(o_pll_mult, prcc_pkg::MULT_X4);
      check(o_volt.analog, prcc_pkg::AN_3V6);
      i_usb_connected <= 1'b0;
      i_player_mode <= 1'b0;
      i_prcc_partner.set_pin(2, 1'b1);
      repeat (4) pulse(7);
      check(o_status.analog_low, 1'b1);
      i_prcc_partner.set_pin(2, 1'b0);
      pulse(3);
      check(o_analog_drv_en, 1'b1);
      pulse(4);
      check(o_analog_drv_en, 1'b0);
   endtask

   // raise one reset source and judge the reset it causes
   task automatic hit(input int which, input int bound);
      pulse(2);
      if (which == 4)
      begin
         i_wdog_en <= 1'b1;
         pulse(5);
      end
      else
         i_prcc_partner.set_pin(which, 1'b1);
      wait_until(1, 1'b0, bound);
      repeat (2) @(posedge i_sys_clk);
      #1;
      check(o_reg_enable, 1'b1);
      check(o_volt, prcc_pkg::VOLT_DEF);
      if (which == 1)
      begin
         check(o_clk_buf_en, 1'b0);
         check(o_digital_pd, 1'b1);
      end
      @(posedge i_sys_clk);
      i_wdog_en <= 1'b0;
      i_prcc_partner.set_pin(which, 1'b0);
      wait_until(1, 1'b1, 40);
   endtask

   // key hold power-down, restart, then software shutdown
   task automatic t_power_down();
      i_auto_off_en <= 1'b1;
      i_prcc_partner.set_pin(3, 1'b1);
      wait_until(0, 1'b0, AUTO + 20);
      check(o_sys_reset_n, 1'b0);
      @(posedge i_sys_clk);
      i_auto_off_en <= 1'b0;
      i_prcc_partner.set_pin(3, 1'b0);
      i_prcc_partner.press(START + 4);
      wait_until(1, 1'b1, 60);
      pulse(6);
      wait_until(0, 1'b0, 5);
      check(o_reg_enable, 1'b0);
      check(o_status.reg_on, 1'b0);
   endtask

   // main sequence
   initial
   begin
      {i_sys_clk, i_rstn, i_reg_shutdown, i_volt_wr, i_auto_off_en, i_mult_wr} = '0;
      {i_usb_connected, i_player_mode, i_wdog_en, i_wdog_kick, i_decode_start} = '0;
      {i_decode_stop, i_cause_clr, i_mult, i_song_mult} = '0;
      i_volt_cfg = prcc_pkg::VOLT_DEF;
      err_total = 0;
      checks = 0;
      repeat (2) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      t_power_up();
      t_key_status();
      t_settings();
      i_prcc_partner.set_pin(4, 1'b1);
      hit(0, 20);
      check(o_status.cause, 4'h1);
      repeat (2) @(posedge i_sys_clk);
      #1;
      check(o_volt.io, prcc_pkg::IO_1V8);
      i_prcc_partner.set_pin(4, 1'b0);
      hit(1, 20);
      check(o_status.cause, 4'h8);
      hit(4, WDOG + 60);
      check(o_status.cause, 4'h4);
      hit(3, LONGC + 20);
      check(o_status.cause, 4'h2);
      t_power_down();
      tally_and_finish();
   end
endmodule // testbench
